// ==== common/hub_strap_consts.vh ====
// constants for the hub strap sampler: register map, field positions, reset values, timing
`ifndef HUB_STRAP_CONSTS_VH
`define HUB_STRAP_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_CTRL            12'h000
`define REG_STATUS          12'h004
`define REG_PINS            12'h008

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_HS_BIT         0
`define CTRL_CONF_BIT       1
`define CTRL_SUSP_BIT       2
`define CTRL_PP_LSB         8
`define CTRL_RESET          1'b0

// ----------------------------------------
// status register fields
// ----------------------------------------
`define STAT_DONE_BIT       0
`define STAT_CFG_LSB        1
`define STAT_STRAPEN_BIT    3
`define STAT_SELFPWR_BIT    4
`define STAT_FIXCODE_LSB    5
`define STAT_COMPOUND_BIT   7
`define STAT_CHARGE_LSB     8
`define STAT_FIXMASK_LSB    16
`define STAT_SPDSTRAP_BIT   24
`define STAT_ACTSTRAP_BIT   25

// ----------------------------------------
// configuration select codes
// ----------------------------------------
`define CFG_DEFAULT         2'b00
`define CFG_SMBUS           2'b01
`define CFG_BUS_POWERED     2'b10
`define CFG_EEPROM          2'b11

// ----------------------------------------
// timing and reset values
// ----------------------------------------
`define SETTLE_CYCLES       4'h8
`define STRAP_RESET         1'b0

`endif

// ==== design/pin_sync3.v ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module pin_sync3 #(
    parameter WIDTH = 8
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // raw pins and filtered levels
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] level
);

    reg  [WIDTH-1:0] s1_r;
    reg  [WIDTH-1:0] s2_r;
    reg  [WIDTH-1:0] s3_r;
    reg  [WIDTH-1:0] level_r;
    wire [WIDTH-1:0] agree;

    // a change counts only once stages two and three match
    assign agree = ~(s2_r ^ s3_r);
    assign level = level_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r    <= {WIDTH{1'b0}};
            s2_r    <= {WIDTH{1'b0}};
            s3_r    <= {WIDTH{1'b0}};
            level_r <= {WIDTH{1'b0}};
        end else begin
            s1_r    <= pin_in;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            level_r <= (agree & s3_r) | (~agree & level_r);
        end
    end

endmodule // pin_sync3

`default_nettype wire

// ==== design/hub_strap_sampler_status_leds.v ====
// hub strap sampler: reset-time strap capture, shared-pin indicators, apb registers
`timescale 1ns/100ps
`default_nettype none
`include "hub_strap_consts.vh"

module hub_strap_sampler_status_leds #(
    parameter NPORTS = 4
) (
    // clock and reset
    input  wire              pclk,
    input  wire              presetn,
    // apb slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output wire [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    // speed indicator pin, doubles as config select bit1 strap
    input  wire              upstream_speed_indicator_in,
    output wire              upstream_speed_indicator_out,
    output wire              upstream_speed_indicator_oe_n,
    // activity pin, doubles as self power detect and fixed port strap bit0
    input  wire              activity_indicator_in,
    output wire              activity_indicator_out,
    output wire              activity_indicator_oe_n,
    // strap-only inputs shared with the serial port
    input  wire              config_select_bit0_in,
    input  wire              fixed_port_strap_bit1_in,
    // port power pins, double as charge enable straps
    input  wire [NPORTS-1:0] charge_enable_strap,
    output wire [NPORTS-1:0] port_power_output,
    output wire [NPORTS-1:0] port_power_oe_n,
    // decoded configuration toward the hub core
    output wire              straps_done,
    output wire [1:0]        config_method,
    output wire              straps_enabled,
    output wire              self_powered,
    output wire [1:0]        fixed_port_code,
    output wire [NPORTS-1:0] fixed_port_mask,
    output wire              compound_device,
    output wire [NPORTS-1:0] charge_enable
);

    // ----------------------------------------
    // local parameters
    // ----------------------------------------
    localparam SW = 4 + NPORTS;

    localparam ST_SETTLE = 2'b00;
    localparam ST_LATCH  = 2'b01;
    localparam ST_RUN    = 2'b10;

    localparam IX_SPD = 0;
    localparam IX_ACT = 1;
    localparam IX_CF0 = 2;
    localparam IX_FX1 = 3;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    // which ports carry a permanently attached device
    function [NPORTS-1:0] fixed_mask;
        input [1:0] code;
        reg   [7:0] m;
        begin
            case (code)
                2'b00:   m = 8'h00;
                2'b01:   m = 8'h01;
                2'b10:   m = 8'h03;
                2'b11:   m = 8'h07;
                default: m = 8'h00;
            endcase
            fixed_mask = m[NPORTS-1:0];
        end
    endfunction

    // pin level for an indicator: strap high means led wired active low
    function led_level;
        input lit;
        input strap;
        begin
            led_level = lit ^ strap;
        end
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [1:0]        state_r;
    reg [1:0]        state_nxt;
    reg [3:0]        settle_r;

    reg              spd_strap_r;
    reg              act_strap_r;
    reg [1:0]        cfg_r;
    reg              strapen_r;
    reg              selfpwr_r;
    reg [1:0]        fixcode_r;
    reg [NPORTS-1:0] fixmask_r;
    reg              compound_r;
    reg [NPORTS-1:0] charge_r;
    reg              done_r;

    reg              ctrl_hs_r;
    reg              ctrl_conf_r;
    reg              ctrl_susp_r;
    reg [NPORTS-1:0] ctrl_pp_r;

    reg              spd_out_r;
    reg              spd_oe_n_r;
    reg              act_out_r;
    reg              act_oe_n_r;
    reg [NPORTS-1:0] pp_out_r;
    reg [NPORTS-1:0] pp_oe_n_r;

    reg [31:0]       prdata_r;
    reg              pready_r;
    reg              pslverr_r;

    wire [SW-1:0]    raw_pins;
    wire [SW-1:0]    pin_level;
    wire             setup_phase;
    wire             ctrl_write;
    wire             addr_hit;
    wire [31:0]      status_word;
    wire [31:0]      ctrl_word;
    wire [31:0]      pins_word;
    wire [1:0]       cfg_now;
    wire             strapen_now;
    wire [1:0]       fixcode_now;

    // ----------------------------------------
    // pin synchroniser
    // ----------------------------------------
    assign raw_pins = {charge_enable_strap,
                       fixed_port_strap_bit1_in,
                       config_select_bit0_in,
                       activity_indicator_in,
                       upstream_speed_indicator_in};

    pin_sync3 #(
        .WIDTH (SW)
    ) u_sync (
        .clk    (pclk),
        .rst_n  (presetn),
        .pin_in (raw_pins),
        .level  (pin_level)
    );

    // ----------------------------------------
    // strap decode at the latch point
    // ----------------------------------------
    // sampled level is taken as the option bit as is
    assign cfg_now     = {pin_level[IX_SPD], pin_level[IX_CF0]};
    // only the two internal-default methods use the straps
    assign strapen_now = (cfg_now == `CFG_DEFAULT) ||
                         (cfg_now == `CFG_BUS_POWERED);
    assign fixcode_now = strapen_now ? {pin_level[IX_FX1], pin_level[IX_ACT]}
                                     : 2'b00;

    // ----------------------------------------
    // sampling sequence
    // ----------------------------------------
    // pins stay released while the synchroniser fills, so the
    // board resistors alone set the level seen at the latch point
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_SETTLE: begin
                if (settle_r == `SETTLE_CYCLES) begin
                    state_nxt = ST_LATCH;
                end
            end
            ST_LATCH: begin
                state_nxt = ST_RUN;
            end
            ST_RUN: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_SETTLE;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r  <= ST_SETTLE;
            settle_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_SETTLE) begin
                settle_r <= settle_r + 4'h1;
            end
        end
    end

    // ----------------------------------------
    // strap latches
    // ----------------------------------------
    // written once after reset release and never again until reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spd_strap_r <= `STRAP_RESET;
            act_strap_r <= `STRAP_RESET;
            cfg_r       <= 2'b00;
            strapen_r   <= 1'b0;
            selfpwr_r   <= 1'b0;
            fixcode_r   <= 2'b00;
            fixmask_r   <= {NPORTS{1'b0}};
            compound_r  <= 1'b0;
            charge_r    <= {NPORTS{1'b0}};
            done_r      <= 1'b0;
        end else if (state_r == ST_LATCH) begin
            spd_strap_r <= pin_level[IX_SPD];
            act_strap_r <= pin_level[IX_ACT];
            cfg_r       <= cfg_now;
            strapen_r   <= strapen_now;
            // high means a local supply; bus-powered override forces off
            selfpwr_r   <= pin_level[IX_ACT] &&
                           (cfg_now != `CFG_BUS_POWERED);
            fixcode_r   <= fixcode_now;
            fixmask_r   <= fixed_mask(fixcode_now);
            compound_r  <= (fixcode_now != 2'b00);
            charge_r    <= strapen_now ? pin_level[SW-1:4]
                                       : {NPORTS{1'b0}};
            done_r      <= 1'b1;
        end
    end

    // ----------------------------------------
    // shared pin drivers
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spd_out_r  <= 1'b0;
            spd_oe_n_r <= 1'b1;
            act_out_r  <= 1'b0;
            act_oe_n_r <= 1'b1;
            pp_out_r   <= {NPORTS{1'b0}};
            pp_oe_n_r  <= {NPORTS{1'b1}};
        end else if (state_r == ST_RUN) begin
            spd_oe_n_r <= 1'b0;
            act_oe_n_r <= 1'b0;
            pp_oe_n_r  <= {NPORTS{1'b0}};
            spd_out_r  <= led_level(ctrl_hs_r, spd_strap_r);
            // activity pin strap is fixed code bit0: 0 gives active high
            act_out_r  <= led_level(ctrl_conf_r && !ctrl_susp_r,
                                    act_strap_r);
            // charge-enabled ports power up without host help
            pp_out_r   <= charge_r | ctrl_pp_r;
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    // zero-wait: pready is raised in the access cycle after setup
    assign setup_phase = psel && !penable;
    assign addr_hit    = (paddr == `REG_CTRL) ||
                         (paddr == `REG_STATUS) ||
                         (paddr == `REG_PINS);
    assign ctrl_write  = psel && penable && pready_r && pwrite &&
                         (paddr == `REG_CTRL);

    assign ctrl_word = ({31'h0, ctrl_hs_r} << `CTRL_HS_BIT) |
                       ({31'h0, ctrl_conf_r} << `CTRL_CONF_BIT) |
                       ({31'h0, ctrl_susp_r} << `CTRL_SUSP_BIT) |
                       ({{(32-NPORTS){1'b0}}, ctrl_pp_r} << `CTRL_PP_LSB);

    assign status_word =
        ({31'h0, done_r} << `STAT_DONE_BIT) |
        ({30'h0, cfg_r} << `STAT_CFG_LSB) |
        ({31'h0, strapen_r} << `STAT_STRAPEN_BIT) |
        ({31'h0, selfpwr_r} << `STAT_SELFPWR_BIT) |
        ({30'h0, fixcode_r} << `STAT_FIXCODE_LSB) |
        ({31'h0, compound_r} << `STAT_COMPOUND_BIT) |
        ({{(32-NPORTS){1'b0}}, charge_r} << `STAT_CHARGE_LSB) |
        ({{(32-NPORTS){1'b0}}, fixmask_r} << `STAT_FIXMASK_LSB) |
        ({31'h0, spd_strap_r} << `STAT_SPDSTRAP_BIT) |
        ({31'h0, act_strap_r} << `STAT_ACTSTRAP_BIT);

    assign pins_word = {{(32-SW){1'b0}}, pin_level};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            pready_r <= setup_phase;
            if (setup_phase) begin
                pslverr_r <= !addr_hit;
                if (pwrite || !addr_hit) begin
                    prdata_r <= 32'h0;
                end else if (paddr == `REG_CTRL) begin
                    prdata_r <= ctrl_word;
                end else if (paddr == `REG_STATUS) begin
                    prdata_r <= status_word;
                end else begin
                    prdata_r <= pins_word;
                end
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    // stands in for the hub core's link speed and usb state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_hs_r   <= `CTRL_RESET;
            ctrl_conf_r <= `CTRL_RESET;
            ctrl_susp_r <= `CTRL_RESET;
            ctrl_pp_r   <= {NPORTS{`CTRL_RESET}};
        end else if (ctrl_write) begin
            ctrl_hs_r   <= pwdata[`CTRL_HS_BIT];
            ctrl_conf_r <= pwdata[`CTRL_CONF_BIT];
            ctrl_susp_r <= pwdata[`CTRL_SUSP_BIT];
            ctrl_pp_r   <= pwdata[`CTRL_PP_LSB +: NPORTS];
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign prdata                        = prdata_r;
    assign pready                        = pready_r;
    assign pslverr                       = pslverr_r;
    assign upstream_speed_indicator_out  = spd_out_r;
    assign upstream_speed_indicator_oe_n = spd_oe_n_r;
    assign activity_indicator_out        = act_out_r;
    assign activity_indicator_oe_n       = act_oe_n_r;
    assign port_power_output             = pp_out_r;
    assign port_power_oe_n               = pp_oe_n_r;
    assign straps_done                   = done_r;
    assign config_method                 = cfg_r;
    assign straps_enabled                = strapen_r;
    assign self_powered                  = selfpwr_r;
    assign fixed_port_code               = fixcode_r;
    assign fixed_port_mask               = fixmask_r;
    assign compound_device               = compound_r;
    assign charge_enable                 = charge_r;

endmodule // hub_strap_sampler_status_leds

`default_nettype wire

// ==== sim/hub_strap_sampler_status_leds_sva.sv ====
// port checker for the hub strap sampler
`timescale 1ns/100ps
`default_nettype none
`include "hub_strap_consts.vh"
module hub_strap_sva #(
    parameter NPORTS = 4
) (
    // clock, reset, apb
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic              pready,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    // shared pins
    input wire logic              upstream_speed_indicator_in,
    input wire logic              upstream_speed_indicator_out,
    input wire logic              upstream_speed_indicator_oe_n,
    input wire logic              activity_indicator_in,
    input wire logic              activity_indicator_out,
    input wire logic              config_select_bit0_in,
    input wire logic              fixed_port_strap_bit1_in,
    input wire logic [NPORTS-1:0] charge_enable_strap,
    input wire logic [NPORTS-1:0] port_power_output,
    // decoded configuration
    input wire logic              straps_done,
    input wire logic [1:0]        config_method,
    input wire logic              straps_enabled,
    input wire logic              self_powered,
    input wire logic [1:0]        fixed_port_code,
    input wire logic              compound_device,
    input wire logic [NPORTS-1:0] charge_enable
);
    logic              done_q;
    logic              act_s;
    logic              hs_q;
    logic              lit_q;
    logic [NPORTS-1:0] pp_q;
    wire logic         wr_ctrl = psel && penable && pready && pwrite && paddr == `REG_CTRL;

    // shadow of the control word: led levels lag it by one edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            act_s  <= 1'b0;
            hs_q   <= 1'b0;
            lit_q  <= 1'b0;
            pp_q   <= '0;
        end else begin
            done_q <= straps_done;
            if (straps_done && !done_q) begin
                act_s <= activity_indicator_in;
            end
            if (wr_ctrl) begin
                hs_q  <= pwdata[0];
                lit_q <= pwdata[1] & ~pwdata[2];
                pp_q  <= pwdata[8 +: NPORTS];
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_latch; $rose(straps_done); endsequence
    sequence s_run; straps_done && $past(straps_done, 2); endsequence

    property p_cfg; s_latch |-> config_method == {upstream_speed_indicator_in, config_select_bit0_in}; endproperty
    property p_fix; s_latch ##0 straps_enabled |-> fixed_port_code == {fixed_port_strap_bit1_in,
        activity_indicator_in} && charge_enable == charge_enable_strap; endproperty
    property p_self; s_latch |-> self_powered == (activity_indicator_in && config_method != 2'b10); endproperty
    property p_spd; s_run |-> upstream_speed_indicator_out == ($past(hs_q) ^ config_method[1]); endproperty
    property p_act; s_run |-> activity_indicator_out == ($past(lit_q) ^ act_s); endproperty
    property p_pwr; s_run |-> port_power_output == ($past(pp_q) | charge_enable); endproperty
    property p_drive; upstream_speed_indicator_oe_n == !$past(straps_done); endproperty
    property p_gate; straps_done && !straps_enabled |-> fixed_port_code == 2'b00 && charge_enable == '0; endproperty
    property p_en; straps_done |-> straps_enabled == !config_method[0]; endproperty
    property p_cmp; straps_done |-> compound_device == (fixed_port_code != 2'b00); endproperty
    property p_hold; straps_done |=> $stable({straps_done, config_method, fixed_port_code, charge_enable}); endproperty

    a_cfg: assert property (p_cfg) else $error("config select not taken from pins");
    a_fix: assert property (p_fix) else $error("fixed code or charge straps wrong");
    a_self: assert property (p_self) else $error("self power wrong");
    a_spd: assert property (p_spd) else $error("speed led level wrong");
    a_act: assert property (p_act) else $error("activity led level wrong");
    a_pwr: assert property (p_pwr) else $error("port power wrong");
    a_drive: assert property (p_drive) else $error("speed pin drive wrong");
    a_gate: assert property (p_gate) else $error("straps honoured while disabled");
    a_en: assert property (p_en) else $error("strap enable decode wrong");
    a_cmp: assert property (p_cmp) else $error("compound flag wrong");
    a_hold: assert property (p_hold) else $error("latched straps changed");
endmodule // hub_strap_sva

bind hub_strap_sampler_status_leds hub_strap_sva #(.NPORTS(NPORTS)) u_sva (
    .pclk, .presetn, .psel, .penable, .pwrite, .pready, .paddr, .pwdata,
    .upstream_speed_indicator_in, .upstream_speed_indicator_out, .upstream_speed_indicator_oe_n,
    .activity_indicator_in, .activity_indicator_out, .config_select_bit0_in, .fixed_port_strap_bit1_in,
    .charge_enable_strap, .port_power_output, .straps_done, .config_method, .straps_enabled,
    .self_powered, .fixed_port_code, .compound_device, .charge_enable
);
`default_nettype wire

// ==== sim/board_strap_model.sv ====
// board side of the shared pins: strap resistors and led wiring
`timescale 1ns/100ps
`default_nettype none
module board_strap_model #(
    parameter NPORTS = 4
) (
    // strap settings
    input  wire logic              spd_strap,
    input  wire logic              act_strap,
    input  wire logic              cfg0_strap,
    input  wire logic              fix1_strap,
    input  wire logic [NPORTS-1:0] chg_strap,
    // device drive
    input  wire logic              spd_out,
    input  wire logic              spd_oe_n,
    input  wire logic              act_out,
    input  wire logic              act_oe_n,
    input  wire logic [NPORTS-1:0] pp_out,
    input  wire logic [NPORTS-1:0] pp_oe_n,
    // pin levels
    output wire logic              spd_pin,
    output wire logic              act_pin,
    output wire logic              cfg0_pin,
    output wire logic              fix1_pin,
    output wire logic [NPORTS-1:0] pp_pin
);
    // a released pin settles to its strap resistor
    assign spd_pin  = spd_oe_n ? spd_strap : spd_out;
    assign act_pin  = act_oe_n ? act_strap : act_out;
    assign cfg0_pin = cfg0_strap;
    assign fix1_pin = fix1_strap;
    assign pp_pin   = (pp_oe_n & chg_strap) | (~pp_oe_n & pp_out);
endmodule // board_strap_model
`default_nettype wire

// ==== sim/tb_hub_strap_sampler_status_leds.sv ====
// self-checking bench for the hub strap sampler
`timescale 1ns/100ps
`default_nettype none
`include "hub_strap_consts.vh"
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (x)); end end
module tb_hub_strap_sampler_status_leds;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        s_spd, s_act, s_cfg0, s_fix1, spd_pin, act_pin, cfg0_pin, fix1_pin;
    logic        spd_out, spd_oe_n, act_out, act_oe_n;
    logic [3:0]  s_chg, pp_pin, pp_out, pp_oe_n, fixed_port_mask, charge_enable;
    logic        straps_done, straps_enabled, self_powered, compound_device;
    logic [1:0]  config_method, fixed_port_code;
    int          n_mismatch, samples_checked, cyc, i;

    hub_strap_sampler_status_leds #(.NPORTS(4)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .upstream_speed_indicator_in(spd_pin), .upstream_speed_indicator_out(spd_out),
        .upstream_speed_indicator_oe_n(spd_oe_n), .activity_indicator_in(act_pin),
        .activity_indicator_out(act_out), .activity_indicator_oe_n(act_oe_n),
        .config_select_bit0_in(cfg0_pin), .fixed_port_strap_bit1_in(fix1_pin),
        .charge_enable_strap(pp_pin), .port_power_output(pp_out), .port_power_oe_n(pp_oe_n),
        .straps_done, .config_method, .straps_enabled, .self_powered, .fixed_port_code,
        .fixed_port_mask, .compound_device, .charge_enable
    );
    board_strap_model #(.NPORTS(4)) u_board (
        .spd_strap(s_spd), .act_strap(s_act), .cfg0_strap(s_cfg0), .fix1_strap(s_fix1), .chg_strap(s_chg),
        .spd_out, .spd_oe_n, .act_out, .act_oe_n, .pp_out, .pp_oe_n,
        .spd_pin, .act_pin, .cfg0_pin, .fix1_pin, .pp_pin
    );

    // 125 MHz stands in for the board reference clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end

    // ----------------------------------------
    // expectations and bus cycles
    // ----------------------------------------
    function automatic logic [31:0] exp_status(input logic [1:0] cfg, input logic f1, input logic a,
                                               input logic [3:0] chg);
        logic [1:0]  fx;
        logic [31:0] s;
        fx = cfg[0] ? 2'b00 : {f1, a};
        s = 32'h00000000;
        s[3:0] = {!cfg[0], cfg, 1'b1};
        s[4] = a && cfg != 2'b10;
        s[7:5] = {fx != 2'b00, fx};
        s[11:8] = cfg[0] ? 4'h0 : chg;
        s[19:16] = 4'h7 >> (2'd3 - fx);
        s[25:24] = {a, cfg[1]};
        return s;
    endfunction

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic trial(input int n, input logic [1:0] cfg, input logic f1, input logic a,
                         input logic [3:0] chg, input logic [31:0] ctl);
        logic [31:0] r, st, m;
        logic        e;
        int          k;
        st = exp_status(cfg, f1, a, chg);
        m = 32'h00000F07;
        presetn <= 1'b0;
        {s_spd, s_cfg0, s_fix1, s_act, s_chg} <= {cfg, f1, a, chg};
        repeat (5) @(posedge pclk);
        // in reset: nothing latched, every shared pin released, no port powered
        `CHK({straps_done, spd_oe_n, act_oe_n, pp_oe_n, pp_out}, 11'h3F0)
        // one reset cut short in mid-settle
        if (n == 5) begin
            presetn <= 1'b1;
            repeat (4) @(posedge pclk);
            presetn <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        presetn <= 1'b1;
        k = 0;
        while (straps_done !== 1'b1 && k < 40) begin
            @(posedge pclk);
            k++;
        end
        // strap-only lines move after the latch; the latch must not follow
        s_cfg0 <= !cfg[0];
        s_fix1 <= !f1;
        repeat (3) @(posedge pclk);
        `CHK(config_method, cfg)
        `CHK(straps_enabled, st[3])
        `CHK(self_powered, st[4])
        `CHK(fixed_port_code, st[6:5])
        `CHK(fixed_port_mask, st[19:16])
        `CHK(compound_device, st[7])
        `CHK(charge_enable, st[11:8])
        apb(1'b1, `REG_STATUS, 32'hFFFFFFFF, r, e);
        apb(1'b0, `REG_STATUS, 32'h00000000, r, e);
        `CHK(r, st)
        apb(1'b0, 12'h00C, 32'h00000000, r, e);
        `CHK({e, r}, 33'h100000000)
        apb(1'b0, `REG_PINS, 32'h00000000, r, e);
        `CHK(r[3:2], {!f1, !cfg[0]})
        apb(1'b1, `REG_CTRL, ctl, r, e);
        repeat (2) @(posedge pclk);
        `CHK(spd_out, ctl[0] ^ cfg[1])
        `CHK(act_out, (ctl[1] & ~ctl[2]) ^ a)
        `CHK({spd_oe_n, act_oe_n, pp_oe_n}, 6'h00)
        `CHK(pp_out, st[11:8] | ctl[11:8])
        apb(1'b0, `REG_CTRL, 32'h00000000, r, e);
        `CHK(r & m, ctl & m)
        $display("test %0d done", n);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence: every select and fixed code, then random
    // ----------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {s_spd, s_act, s_cfg0, s_fix1, s_chg} = '0;
        {n_mismatch, samples_checked, cyc} = '0;
        i = $urandom(15045);
        for (i = 0; i < 16; i++) trial(i, i[3:2], i[1], i[0], 4'($urandom), $urandom);
        for (i = 16; i < 24; i++) trial(i, 2'($urandom), 1'($urandom), 1'($urandom), 4'($urandom), $urandom);
        tally_and_finish;
    end
endmodule // tb_hub_strap_sampler_status_leds
`default_nettype wire
